//--- dmrpc_consts.svh
// Constants for the first loop's mode, maintenance reset and phase offset command registers.
// Assumes a 32-bit Avalon-MM slave with byte addresses; register byte address is four times index.
`ifndef DMRPC_CONSTS_SVH
`define DMRPC_CONSTS_SVH

// Register indices; the byte address is the index shifted left by two.
`define DMRPC_IDX_USER_MODE     16'h0a22
`define DMRPC_IDX_MAINT_RESET   16'h0a23
`define DMRPC_IDX_PHASE_CMD     16'h0a24
`define DMRPC_IDX_LOOP_STATUS   16'h0a28
`define DMRPC_IDX_PHASE_VALUE   16'h0a29

// Reset values of the software registers.
`define DMRPC_RST_USER_MODE     8'h00
`define DMRPC_RST_MAINT_RESET   8'h00
`define DMRPC_RST_PHASE_CMD     8'h00

// Field positions in the user mode register.
`define DMRPC_MANREF_MSB        6
`define DMRPC_MANREF_LSB        5
`define DMRPC_SWMODE_MSB        4
`define DMRPC_SWMODE_LSB        2
`define DMRPC_HOLDOVER_BIT      1
`define DMRPC_FREERUN_BIT       0

// Field positions in the maintenance reset register.
`define DMRPC_RST_FILTER_BIT    2
`define DMRPC_RST_HISTORY_BIT   1
`define DMRPC_RST_AUTOSYNC_BIT  0

// Field positions in the phase offset command register.
`define DMRPC_PH_CLEAR_BIT      2
`define DMRPC_PH_DEC_BIT        1
`define DMRPC_PH_INC_BIT        0

// Highest switching mode code that software may program.
`define DMRPC_SWMODE_LAST_USED  3'h4

`endif

//--- dmrpc_pkg.sv
// Types shared by the first loop's control register bank and its helpers.
// Assumes the constants header is compiled alongside.
package dmrpc_pkg;

    // Reference switching state machine modes.
    typedef enum logic [2:0] {
        DMRPC_SW_AUTO_REVERTIVE   = 3'b000,
        DMRPC_SW_AUTO_NONREVERT   = 3'b001,
        DMRPC_SW_MANUAL_FALLBACK  = 3'b010,
        DMRPC_SW_MANUAL_HOLDOVER  = 3'b011,
        DMRPC_SW_MANUAL_NOFALL    = 3'b100
    } dmrpc_swmode_t;

    // Forced operating state handed to the loop.
    typedef enum logic [1:0] {
        DMRPC_LOOP_NORMAL   = 2'b00,
        DMRPC_LOOP_HOLDOVER = 2'b01,
        DMRPC_LOOP_FREERUN  = 2'b10
    } dmrpc_loop_t;

    // Bus answer state machine.
    typedef enum logic [0:0] {
        DMRPC_BUS_IDLE   = 1'b0,
        DMRPC_BUS_ANSWER = 1'b1
    } dmrpc_bus_t;

endpackage

//--- dmrpc_mode_resolve.sv
// Resolves the two forcing bits into one registered loop state.
// Assumes both inputs come from registers on the same clock.
`timescale 1ns/10ps
module dmrpc_mode_resolve (
    input  wire logic                  core_clk,     // System clock.
    input  wire logic                  rst,          // Synchronous reset, active high.
    input  wire logic                  userHoldover, // Forced holdover level.
    input  wire logic                  userFreeRun,  // Forced free run level.
    output dmrpc_pkg::dmrpc_loop_t     loopState     // Registered loop state.
);
    import dmrpc_pkg::*;

    dmrpc_loop_t next_loopState;

    // Free run outranks holdover; either holds only while its bit stays set.
    always_comb begin
        case ({userFreeRun, userHoldover})
            2'b10,
            2'b11:   next_loopState = DMRPC_LOOP_FREERUN;
            2'b01:   next_loopState = DMRPC_LOOP_HOLDOVER;
            default: next_loopState = DMRPC_LOOP_NORMAL;
        endcase
    end

    // Registers the resolved state.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            loopState <= DMRPC_LOOP_NORMAL;
        end else begin
            loopState <= next_loopState;
        end
    end
endmodule

//--- dmrpc_phase_accum.sv
// Incremental phase offset accumulator stepped by one-cycle commands.
// Assumes the step size comes from registers on the same clock.
`timescale 1ns/10ps
module dmrpc_phase_accum #(
    parameter int OFFSET_W = 32, // Width of the accumulated offset.
    parameter int STEP_W   = 16  // Width of the step size.
) (
    input  wire logic                core_clk, // System clock.
    input  wire logic                rst,      // Synchronous reset, active high.
    input  wire logic                clearCmd, // Pulse: return the offset to zero.
    input  wire logic                decCmd,   // Pulse: subtract one step.
    input  wire logic                incCmd,   // Pulse: add one step.
    input  wire logic [STEP_W-1:0]   stepSize, // Programmed step size.
    output logic      [OFFSET_W-1:0] offset    // Accumulated offset, two's complement.
);
    logic [OFFSET_W-1:0] stepWide;

    // Zero-extends the step to the offset width.
    assign stepWide = OFFSET_W'(stepSize);

    // Clear wins over stepping; an increment and decrement together cancel.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            offset <= '0;
        end else if (clearCmd) begin
            offset <= '0;
        end else if (incCmd && !decCmd) begin
            offset <= offset + stepWide;
        end else if (decCmd && !incCmd) begin
            offset <= offset - stepWide;
        end
    end
endmodule

//--- dmrpc_ctrl.sv
// Control register bank for the first digital loop: user mode, maintenance resets,
// and self-clearing phase offset commands, reached over an Avalon-MM slave.
// Assumes one system clock, a synchronous reset, and a step size from its own registers.
//
// Behaviour
// - Manual reference field picks input A, B, C or D; resets to A.
// - Switching mode 000 is automatic revertive, 001 automatic nonrevertive.
// - Switching mode 010 is manual with automatic fallback to another reference.
// - Switching mode 011 is manual with automatic fallback to holdover.
// - Switching mode 100 is manual without fallback; 101 to 111 are unused.
// - User holdover bit set, with free run clear, keeps the loop in holdover until cleared.
// - User free run bit set keeps the loop in free run until cleared.
// - Loop filter reset bit clears the loop filter state, for debugging.
// - Tuning word history reset bit resets the holdover history logic.
// - Autosync reset bit resets the automatic synchronization logic.
// - Phase reset bit returns the incremental offset to zero, then self-clears.
// - Decrement bit subtracts one step from the offset, then self-clears.
// - Increment bit adds one step to the offset, then self-clears.
//
// Chosen here: the Avalon-MM slave port.
`include "dmrpc_consts.svh"
`timescale 1ns/10ps
module dmrpc_ctrl #(
    parameter int OFFSET_W = 32, // Width of the incremental phase offset.
    parameter int STEP_W   = 16  // Width of the phase offset step size.
) (
    input  wire logic                  core_clk,               // System clock, 250 MHz.
    input  wire logic                  rst,                    // Synchronous reset.
    input  wire logic [15:0]           avs_address,            // Byte address.
    input  wire logic                  avs_read,               // Read request.
    input  wire logic                  avs_write,              // Write request.
    input  wire logic [31:0]           avs_writedata,          // Write data.
    input  wire logic [3:0]            avs_byteenable,         // Byte lanes.
    output logic      [31:0]           avs_readdata,           // Read data.
    output logic                       avs_waitrequest,        // Slave not ready.
    input  wire logic [STEP_W-1:0]     stepSize,               // Phase offset step size.
    output logic      [1:0]            manualRef,              // Manual reference choice.
    output dmrpc_pkg::dmrpc_swmode_t   switchMode,             // Switching machine mode.
    output dmrpc_pkg::dmrpc_loop_t     loopState,              // Forced loop state.
    output logic                       loopFilterReset,        // Loop filter held in reset.
    output logic                       tuningWordHistoryReset, // History logic held in reset.
    output logic                       autosyncReset,          // Autosync logic held in reset.
    output logic      [OFFSET_W-1:0]   phaseOffset             // Incremental phase offset.
);
    import dmrpc_pkg::*;

    // Byte addresses of the registers, four times their indices.
    localparam logic [15:0] ADDR_USER_MODE   = 16'(`DMRPC_IDX_USER_MODE << 2);
    localparam logic [15:0] ADDR_MAINT_RESET = 16'(`DMRPC_IDX_MAINT_RESET << 2);
    localparam logic [15:0] ADDR_PHASE_CMD   = 16'(`DMRPC_IDX_PHASE_CMD << 2);
    localparam logic [15:0] ADDR_LOOP_STATUS = 16'(`DMRPC_IDX_LOOP_STATUS << 2);
    localparam logic [15:0] ADDR_PHASE_VALUE = 16'(`DMRPC_IDX_PHASE_VALUE << 2);

    // Reset images of the software registers, sliced field by field below.
    localparam logic [7:0]  RST_USER_MODE    = `DMRPC_RST_USER_MODE;
    localparam logic [7:0]  RST_MAINT_RESET  = `DMRPC_RST_MAINT_RESET;
    localparam logic [7:0]  RST_PHASE_CMD    = `DMRPC_RST_PHASE_CMD;

    // Bus state and decoded strokes.
    dmrpc_bus_t    busState;
    dmrpc_bus_t    next_busState;
    logic [31:0]   next_readData;
    logic          commitWrite;
    logic          lowLane;
    logic [7:0]    wrByte;

    // Software register contents.
    logic          userHoldover;
    logic          userFreeRun;
    logic [2:0]    phaseCmd;
    logic [2:0]    newSwitchCode;
    logic          switchCodeLegal;

    // The write takes effect at the edge where the master sees waitrequest low.
    assign commitWrite = (busState == DMRPC_BUS_ANSWER) && avs_write;
    assign lowLane     = avs_byteenable[0];
    assign wrByte      = avs_writedata[7:0];

    // Switching mode codes above the last used one are refused.
    assign newSwitchCode   = wrByte[`DMRPC_SWMODE_MSB:`DMRPC_SWMODE_LSB];
    assign switchCodeLegal = (newSwitchCode <= `DMRPC_SWMODE_LAST_USED);

    // Every request is answered one cycle after it is first seen.
    always_comb begin
        case (busState)
            DMRPC_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_busState = DMRPC_BUS_ANSWER;
                end else begin
                    next_busState = DMRPC_BUS_IDLE;
                end
            end
            DMRPC_BUS_ANSWER: begin
                next_busState = DMRPC_BUS_IDLE;
            end
            default: begin
                next_busState = DMRPC_BUS_IDLE;
            end
        endcase
    end

    // Advances the bus state machine.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busState <= DMRPC_BUS_IDLE;
        end else begin
            busState <= next_busState;
        end
    end

    // Waitrequest drops for exactly the answer cycle and stays high otherwise.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= (next_busState != DMRPC_BUS_ANSWER);
        end
    end

    // Builds the read word; unmapped addresses read as zero.
    always_comb begin
        next_readData = 32'h0000_0000;
        case (avs_address)
            ADDR_USER_MODE: begin
                next_readData[`DMRPC_MANREF_MSB:`DMRPC_MANREF_LSB] = manualRef;
                next_readData[`DMRPC_SWMODE_MSB:`DMRPC_SWMODE_LSB] = switchMode;
                next_readData[`DMRPC_HOLDOVER_BIT] = userHoldover;
                next_readData[`DMRPC_FREERUN_BIT]  = userFreeRun;
            end
            ADDR_MAINT_RESET: begin
                next_readData[`DMRPC_RST_FILTER_BIT]   = loopFilterReset;
                next_readData[`DMRPC_RST_HISTORY_BIT]  = tuningWordHistoryReset;
                next_readData[`DMRPC_RST_AUTOSYNC_BIT] = autosyncReset;
            end
            ADDR_PHASE_CMD: begin
                next_readData[2:0] = phaseCmd;
            end
            ADDR_LOOP_STATUS: begin
                next_readData[1:0] = loopState;
            end
            ADDR_PHASE_VALUE: begin
                next_readData = 32'(phaseOffset);
            end
            default: begin
                next_readData = 32'h0000_0000;
            end
        endcase
    end

    // Loads read data as waitrequest drops so it stands during the answer cycle.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (next_busState == DMRPC_BUS_ANSWER && avs_read) begin
            avs_readdata <= next_readData;
        end
    end

    // Manual reference choice, A after reset.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            manualRef <= RST_USER_MODE[`DMRPC_MANREF_MSB:`DMRPC_MANREF_LSB];
        end else if (commitWrite && lowLane && avs_address == ADDR_USER_MODE) begin
            manualRef <= wrByte[`DMRPC_MANREF_MSB:`DMRPC_MANREF_LSB];
        end
    end

    // Switching mode, automatic revertive after reset; unused codes keep the old mode.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            switchMode <= dmrpc_swmode_t'(RST_USER_MODE[`DMRPC_SWMODE_MSB:`DMRPC_SWMODE_LSB]);
        end else if (commitWrite && lowLane && avs_address == ADDR_USER_MODE
                     && switchCodeLegal) begin
            switchMode <= dmrpc_swmode_t'(newSwitchCode);
        end
    end

    // Forcing bits, both clear after reset and cleared only by software.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            userHoldover <= RST_USER_MODE[`DMRPC_HOLDOVER_BIT];
            userFreeRun  <= RST_USER_MODE[`DMRPC_FREERUN_BIT];
        end else if (commitWrite && lowLane && avs_address == ADDR_USER_MODE) begin
            userHoldover <= wrByte[`DMRPC_HOLDOVER_BIT];
            userFreeRun  <= wrByte[`DMRPC_FREERUN_BIT];
        end
    end

    // Maintenance resets are levels that hold their logic until written back to zero.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            loopFilterReset        <= RST_MAINT_RESET[`DMRPC_RST_FILTER_BIT];
            tuningWordHistoryReset <= RST_MAINT_RESET[`DMRPC_RST_HISTORY_BIT];
            autosyncReset          <= RST_MAINT_RESET[`DMRPC_RST_AUTOSYNC_BIT];
        end else if (commitWrite && lowLane && avs_address == ADDR_MAINT_RESET) begin
            loopFilterReset        <= wrByte[`DMRPC_RST_FILTER_BIT];
            tuningWordHistoryReset <= wrByte[`DMRPC_RST_HISTORY_BIT];
            autosyncReset          <= wrByte[`DMRPC_RST_AUTOSYNC_BIT];
        end
    end

    // Phase commands stand for one cycle and then clear themselves.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            phaseCmd <= RST_PHASE_CMD[2:0];
        end else if (commitWrite && lowLane && avs_address == ADDR_PHASE_CMD) begin
            phaseCmd <= wrByte[2:0];
        end else begin
            phaseCmd <= 3'h0;
        end
    end

    // Resolves forced holdover and free run into the loop state.
    dmrpc_mode_resolve u_mode (
        .core_clk     (core_clk),
        .rst          (rst),
        .userHoldover (userHoldover),
        .userFreeRun  (userFreeRun),
        .loopState    (loopState)
    );

    // Keeps the incremental phase offset, stepped by the self-clearing commands.
    dmrpc_phase_accum #(
        .OFFSET_W (OFFSET_W),
        .STEP_W   (STEP_W)
    ) u_accum (
        .core_clk (core_clk),
        .rst      (rst),
        .clearCmd (phaseCmd[`DMRPC_PH_CLEAR_BIT]),
        .decCmd   (phaseCmd[`DMRPC_PH_DEC_BIT]),
        .incCmd   (phaseCmd[`DMRPC_PH_INC_BIT]),
        .stepSize (stepSize),
        .offset   (phaseOffset)
    );
endmodule

//--- dmrpc_ctrl_assertions.sv
// Checker for the loop control register bank, bound to its top module.
// Assumes one wait cycle per request and a step size held during commands.
`timescale 1ns/10ps
`include "dmrpc_consts.svh"
module dmrpc_ctrl_assertions #(
    parameter int OFFSET_W = 32, // Offset width.
    parameter int STEP_W   = 16  // Step width.
) (
    input wire logic                core_clk,               // Clock.
    input wire logic                rst,                    // Reset.
    input wire logic [15:0]         avs_address,            // Byte address.
    input wire logic                avs_write,              // Write request.
    input wire logic [31:0]         avs_writedata,          // Write data.
    input wire logic [3:0]          avs_byteenable,         // Byte lanes.
    input wire logic                avs_waitrequest,        // Slave not ready.
    input wire logic [STEP_W-1:0]   stepSize,               // Step size.
    input wire logic [1:0]          manualRef,              // Manual reference.
    input dmrpc_pkg::dmrpc_swmode_t switchMode,             // Switching mode.
    input dmrpc_pkg::dmrpc_loop_t   loopState,              // Loop state.
    input wire logic                loopFilterReset,        // Filter reset.
    input wire logic                tuningWordHistoryReset, // History reset.
    input wire logic                autosyncReset,          // Autosync reset.
    input wire logic [OFFSET_W-1:0] phaseOffset             // Phase offset.
);
    import dmrpc_pkg::*;
    // Committed writes, one flag per register.
    wire logic wrOk = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire logic wrMode = wrOk && avs_address == (`DMRPC_IDX_USER_MODE << 2);
    wire logic wrRst = wrOk && avs_address == (`DMRPC_IDX_MAINT_RESET << 2);
    wire logic wrPh = wrOk && avs_address == (`DMRPC_IDX_PHASE_CMD << 2);
    wire logic [2:0] wd = avs_writedata[2:0];

    // All checks run on the system clock and pause during reset.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest stayed low");
    chk_manref_set: assert property (
        wrMode |=> manualRef == $past(avs_writedata[6:5]))
        else $error("manual reference not written");
    chk_swmode_legal: assert property (
        wrMode && avs_writedata[4:2] <= 3'h4 |=> switchMode == $past(avs_writedata[4:2]))
        else $error("switching mode not written");
    chk_swmode_unused: assert property (
        wrMode && avs_writedata[4:2] > 3'h4 |=> $stable(switchMode))
        else $error("unused switching code taken");
    chk_holdover_state: assert property (
        wrMode && wd[1:0] == 2'b10 |-> ##2 loopState == DMRPC_LOOP_HOLDOVER)
        else $error("holdover not entered");
    chk_freerun_wins: assert property (
        wrMode && wd[0] |-> ##2 loopState == DMRPC_LOOP_FREERUN)
        else $error("free run not entered");
    chk_normal_state: assert property (
        wrMode && wd[1:0] == 2'b00 |-> ##2 loopState == DMRPC_LOOP_NORMAL)
        else $error("normal state not restored");
    chk_maint_levels: assert property (
        wrRst |=> {loopFilterReset, tuningWordHistoryReset, autosyncReset} == $past(wd))
        else $error("maintenance reset levels wrong");
    chk_phase_clear: assert property (
        wrPh && wd[2] |-> ##2 phaseOffset == '0)
        else $error("phase offset not cleared");
    chk_phase_dec: assert property (
        wrPh && wd == 3'b010
        |-> ##2 phaseOffset == $past(phaseOffset, 2) - OFFSET_W'($past(stepSize)))
        else $error("decrement wrong");
    chk_phase_inc: assert property (
        wrPh && wd == 3'b001
        |-> ##2 phaseOffset == $past(phaseOffset, 2) + OFFSET_W'($past(stepSize)))
        else $error("increment wrong");

    // Main scenarios reached.
    cover property (wrMode && wd[1:0] == 2'b11);
    cover property (wrRst && wd == 3'h7);
    cover property (wrPh && wd == 3'b001);
endmodule

bind dmrpc_ctrl dmrpc_ctrl_assertions #(.OFFSET_W(OFFSET_W), .STEP_W(STEP_W)) chk_u (
    .core_clk, .rst, .avs_address, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_waitrequest, .stepSize, .manualRef, .switchMode, .loopState, .loopFilterReset,
    .tuningWordHistoryReset, .autosyncReset, .phaseOffset);

//--- dmrpc_ctrl_tb.sv
// Self-checking bench for the loop control register bank.
// Assumes the bank is the only bus slave and the checker is bound to it.
`timescale 1ns/10ps
`include "dmrpc_consts.svh"
module dmrpc_ctrl_tb;
    import dmrpc_pkg::*;
    localparam logic [15:0] UM = `DMRPC_IDX_USER_MODE << 2;
    logic          core_clk = 1'b0;
    logic          rst = 1'b1;
    logic [15:0]   avs_address = 16'h0000;
    logic          avs_read = 1'b0;
    logic          avs_write = 1'b0;
    logic [31:0]   avs_writedata = 32'h0, avs_readdata, phaseOffset, rd;
    logic [3:0]    avs_byteenable = 4'hf;
    logic [15:0]   stepSize = 16'h0000;
    logic          avs_waitrequest, loopFilterReset, tuningWordHistoryReset, autosyncReset;
    logic [1:0]    manualRef;
    dmrpc_swmode_t switchMode;
    dmrpc_loop_t   loopState;
    int            n_fail = 0, tests_run = 0, um = 0, mr = 0, off = 0, st, v, e;
    int            q[$];

    dmrpc_ctrl dut_u (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .stepSize, .manualRef, .switchMode,
        .loopState, .loopFilterReset, .tuningWordHistoryReset, .autosyncReset, .phaseOffset);

    // Clock of 4 ns period.
    initial forever #2 core_clk = ~core_clk;

    // Compares one value and counts it.
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus cycle, held until waitrequest is sampled low; read data lands in rd.
    task automatic bus(logic wr, logic [15:0] a, logic [31:0] d, logic [3:0] be);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        check("waitrequest", 0, {31'h0, avs_waitrequest});
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Lets registered outputs settle after a write.
    task automatic settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    // Checks every register and output against the model.
    task automatic all_regs;
        check("manualRef", (um >> 5) & 3, 32'(manualRef));
        check("swMode", um >> 2 & 7, 32'(switchMode));
        v = um[0] ? 2 : (um[1] ? 1 : 0);
        check("loopState", v, 32'(loopState));
        check("filter", mr >> 2 & 1, 32'(loopFilterReset));
        check("history", mr >> 1 & 1, 32'(tuningWordHistoryReset));
        check("autosync", mr & 1, 32'(autosyncReset));
        check("phaseOffset", off, phaseOffset);
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, UM + 16'(4 * i), 32'h0, 4'hf);
            e = i == 0 ? um : i == 1 ? mr : i == 6 ? v : i == 7 ? off : 0;
            check("read", e, rd);
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Cuts a hung run short.
    initial begin
        repeat (40000) @(posedge core_clk);
        check("watchdog", 0, 1);
        test_done;
    end

    // Main sequence.
    initial begin
        void'($urandom(78));
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        all_regs;
        bus(1'b1, UM + 16'h000c, 32'hff, 4'hf);
        bus(1'b1, UM + 16'h0018, 32'hff, 4'hf);
        all_regs;
        $display("test reset and unmapped done");
        for (int i = 0; i < 16; i++) begin
            v = ($urandom() & 32'he3) | ((i & 7) << 2);
            if (i == 15)
                bus(1'b1, UM, v, 4'he);
            else begin
                bus(1'b1, UM, v, 4'hf);
                um = (i & 7) <= 4 ? v & 32'h7f : v & 32'h63 | um & 32'h1c;
            end
            settle;
            all_regs;
        end
        $display("test user mode done");
        for (int i = 0; i < 9; i++) begin
            v = (i == 8) ? $urandom() : i;
            mr = v & 7;
            bus(1'b1, UM + 16'h0004, v, 4'hf);
            settle;
            all_regs;
        end
        $display("test maintenance resets done");
        for (int j = 0; j < 2; j++) begin
            @(posedge core_clk);
            st = (j == 0) ? 65535 : int'($urandom() & 32'hffff);
            stepSize <= 16'(st);
            q = {1, 1, 2, 3, 4, 7, 2, 2, 1, 6, 5, 0};
            repeat (6) q.push_back($urandom() & 7);
            foreach (q[k]) begin
                if (q[k] & 4)
                    off = 0;
                else
                    off = off + (q[k] & 1) * st - ((q[k] >> 1) & 1) * st;
                bus(1'b1, UM + 16'h0008, q[k], 4'hf);
                settle;
                all_regs;
            end
        end
        $display("test phase commands done");
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        um = 0;
        mr = 0;
        off = 0;
        settle;
        all_regs;
        $display("test second reset done");
        test_done;
    end
endmodule
